// ==== src/agm_regs.sv ====
// gain, channel select and configuration registers with sar clock and repeat sequencer
// assumes synchronous byte register port from the core and a per-conversion end strobe
//
// Operation
// - extra gain register at indirect 0x08, bit 0 only, resets to one
// - channel select at 0xbb, five-bit input code, 0x1a..0x1f mean ground, reset 0x1f
// - configuration at 0xbc resets 0xf8: divider, repeat count, gain programming enable
// - sar clock is source clock over divider plus one; burst source at most 25 MHz
// - with gain enable, result high is gain address, result low its write-only data
// - effective gain is gain word over 4096 plus 1/64 when extra bit set
`timescale 1ns/1ps
module agm_regs (
    input  wire logic         clk,
    input  wire logic         rstn,
    input  wire logic [7:0]   sfr_addr,
    input  wire logic         sfr_wr,
    input  wire logic         sfr_rd,
    input  wire logic [7:0]   sfr_wdata,
    output logic      [7:0]   sfr_rdata,
    input  wire logic         burst_enable,
    input  wire logic         convert_start,
    input  wire logic         conversion_end,
    output logic      [4:0]   input_select_field,
    output logic              ground_selected,
    output logic              sar_clock_tick,
    output logic              conversion_go,
    output logic              accumulate_clear,
    output logic              conversion_done_set,
    output logic      [4:0]   conversion_total,
    output logic      [11:0]  gain_word,
    output logic              extra_gain_bit,
    output logic      [12:0]  effective_gain,
    output logic              gain_program_enable
);
    import agm_pkg::*;

    logic [7:0]  chan_ff;
    logic [7:0]  cfg_ff;
    logic [7:0]  gain_addr_ff;
    logic [7:0]  gain_high_ff;
    logic [3:0]  gain_low_ff;
    logic        extra_ff;
    logic [7:0]  rdata_ff;
    logic [4:0]  total_ff;
    logic [4:0]  cnt_ff;
    logic        go_ff;
    logic        clr_ff;
    logic        done_ff;
    logic        gnd_ff;
    logic [12:0] eff_ff;
    agm_seq_e    state_ff;
    agm_seq_e    nxt_state;
    logic        burst_tick;
    logic        sar_tick;

    function automatic logic [4:0] repeat_total(input logic [1:0] code);
        unique case (code)
            2'b00: repeat_total = 5'h01;
            2'b01: repeat_total = 5'h04;
            2'b10: repeat_total = 5'h08;
            2'b11: repeat_total = 5'h10;
        endcase
    endfunction : repeat_total

    // register decode
    wire        wr_chan   = sfr_wr && (sfr_addr == ADDR_INPUT_CHANNEL_SELECT);
    wire        wr_cfg    = sfr_wr && (sfr_addr == ADDR_CONVERTER_CONFIGURATION);
    wire        gain_en   = cfg_ff[GAIN_EN_BIT];
    wire        wr_gaddr  = sfr_wr && gain_en && (sfr_addr == ADDR_RESULT_HIGH);
    wire        wr_gdata  = sfr_wr && gain_en && (sfr_addr == ADDR_RESULT_LOW);
    wire [4:0]  sar_div   = cfg_ff[SAR_DIV_LSB +: SAR_DIV_W];
    wire [1:0]  rpt_code  = cfg_ff[REPEAT_LSB +: 2];
    wire [7:0]  rd_mux    = (sfr_addr == ADDR_INPUT_CHANNEL_SELECT)    ? chan_ff :
                            (sfr_addr == ADDR_CONVERTER_CONFIGURATION) ? cfg_ff  : 8'h00;
    wire [4:0]  in_code   = chan_ff[INPUT_SEL_W-1:0];
    wire        last_conv = (cnt_ff == total_ff - 5'h01);
    wire        src_tick  = burst_enable ? burst_tick : 1'b1;
    wire [12:0] nxt_eff   = {1'b0, gain_high_ff, gain_low_ff}
                            + (extra_ff ? EXTRA_GAIN_UNITS : 13'h0000);

    always_ff @(posedge clk) begin
        if (!rstn) begin
            chan_ff <= RST_INPUT_CHANNEL;
            cfg_ff  <= RST_CONFIGURATION;
        end else begin
            if (wr_chan)
                chan_ff <= {3'b000, sfr_wdata[INPUT_SEL_W-1:0]};
            if (wr_cfg)
                cfg_ff <= sfr_wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            gain_addr_ff <= 8'h00;
            gain_high_ff <= RST_GAIN_HIGH_BYTE;
            gain_low_ff  <= RST_GAIN_LOW_NIBBLE;
            extra_ff     <= RST_EXTRA_GAIN[0];
        end else begin
            if (wr_gaddr)
                gain_addr_ff <= sfr_wdata;
            if (wr_gdata && gain_addr_ff == GADDR_GAIN_HIGH_BYTE)
                gain_high_ff <= sfr_wdata;
            if (wr_gdata && gain_addr_ff == GADDR_GAIN_LOW_NIBBLE)
                gain_low_ff <= sfr_wdata[GAIN_NIB_LSB +: 4];
            if (wr_gdata && gain_addr_ff == GADDR_EXTRA_GAIN)
                extra_ff <= sfr_wdata[0];
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            rdata_ff <= 8'h00;
            eff_ff   <= 13'h0000;
            gnd_ff   <= 1'b1;
        end else begin
            eff_ff <= nxt_eff;
            gnd_ff <= (in_code >= GROUND_FIRST_CODE);
            if (sfr_rd)
                rdata_ff <= rd_mux;
        end
    end

    // burst source clock then sar divider
    agm_tick_div #(.WIDTH(2)) u_burst_div (
        .clk      (clk),
        .rstn     (rstn),
        .tick_in  (1'b1),
        .div      (BURST_DIV_M1),
        .tick_out (burst_tick)
    );
    agm_tick_div #(.WIDTH(SAR_DIV_W)) u_sar_div (
        .clk      (clk),
        .rstn     (rstn),
        .tick_in  (src_tick),
        .div      (sar_div),
        .tick_out (sar_tick)
    );

    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            AGM_IDLE:       if (convert_start) nxt_state = AGM_RUN;
            AGM_RUN:        if (conversion_end)
                                nxt_state = last_conv ? AGM_IDLE :
                                            (burst_enable ? AGM_RUN : AGM_WAIT_START);
            AGM_WAIT_START: if (convert_start) nxt_state = AGM_RUN;
        endcase
    end

    wire start_first = (state_ff == AGM_IDLE) && convert_start;
    wire start_next  = (state_ff == AGM_WAIT_START) && convert_start;
    wire end_more    = (state_ff == AGM_RUN) && conversion_end && !last_conv;
    wire end_last    = (state_ff == AGM_RUN) && conversion_end && last_conv;

    // count, go pulses, flag after last
    always_ff @(posedge clk) begin
        if (!rstn) begin
            state_ff <= AGM_IDLE;
            total_ff <= 5'h01;
            cnt_ff   <= 5'h00;
            go_ff    <= 1'b0;
            clr_ff   <= 1'b0;
            done_ff  <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            go_ff    <= start_first || start_next || (end_more && burst_enable);
            clr_ff   <= start_first;
            done_ff  <= end_last;
            if (start_first) begin
                total_ff <= repeat_total(rpt_code);
                cnt_ff   <= 5'h00;
            end else if (end_more) begin
                cnt_ff <= cnt_ff + 5'h01;
            end
        end
    end

    assign sfr_rdata           = rdata_ff;
    assign input_select_field  = chan_ff[INPUT_SEL_W-1:0];
    assign ground_selected     = gnd_ff;
    assign sar_clock_tick      = sar_tick;
    assign conversion_go       = go_ff;
    assign accumulate_clear    = clr_ff;
    assign conversion_done_set = done_ff;
    assign conversion_total    = total_ff;
    assign gain_word           = {gain_high_ff, gain_low_ff};
    assign extra_gain_bit      = extra_ff;
    assign effective_gain      = eff_ff;
    assign gain_program_enable = cfg_ff[GAIN_EN_BIT];

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    extra_gain_write_a: assert property (
        wr_gdata && gain_addr_ff == GADDR_EXTRA_GAIN |=> extra_gain_bit == $past(sfr_wdata[0]))
        else $error("extra gain bit not written");
    chan_upper_zero_a: assert property (
        wr_chan |=> chan_ff[7:5] == 3'b000 && input_select_field == $past(sfr_wdata[4:0]))
        else $error("channel select write wrong");
    ground_code_a: assert property (
        ##1 ground_selected == ($past(input_select_field) >= 5'h1a))
        else $error("ground decode wrong");
    cfg_write_a: assert property (
        wr_cfg |=> cfg_ff == $past(sfr_wdata))
        else $error("configuration not stored");
    sar_tick_gap_a: assert property (
        sar_clock_tick && sar_div != 5'h00 |=> !sar_clock_tick)
        else $error("sar tick spacing wrong");
    done_count_a: assert property (
        conversion_done_set |-> $past(cnt_ff) == $past(total_ff) - 5'h01)
        else $error("done before last conversion");
    total_map_a: assert property (
        start_first && rpt_code == 2'b11 |=> conversion_total == 5'h10)
        else $error("repeat total wrong");
    gain_blocked_a: assert property (
        sfr_wr && !gain_en && sfr_addr == ADDR_RESULT_LOW |=> $stable(gain_word))
        else $error("gain written without enable");
    eff_gain_a: assert property (
        $stable(gain_word) && $stable(extra_gain_bit) |=>
            effective_gain == {1'b0, $past(gain_word)}
                + ($past(extra_gain_bit) ? EXTRA_GAIN_UNITS : 13'h0000))
        else $error("effective gain wrong");

    burst_run_c: cover property (start_first && burst_enable ##[1:300] conversion_done_set);
    step_run_c: cover property (start_next ##[1:300] conversion_done_set);
    gain_prog_c: cover property (wr_gaddr ##[1:10] wr_gdata);
endmodule : agm_regs

// ==== src/agm_pkg.sv ====
// constants for the converter gain, channel and configuration register slice
// assumes byte-wide special-function-register accesses from the core
package agm_pkg;
    // register addresses
    localparam logic [7:0] ADDR_INPUT_CHANNEL_SELECT    = 8'hbb;
    localparam logic [7:0] ADDR_CONVERTER_CONFIGURATION = 8'hbc;
    localparam logic [7:0] ADDR_RESULT_LOW              = 8'hbd;
    localparam logic [7:0] ADDR_RESULT_HIGH             = 8'hbe;
    // indirect gain register addresses
    localparam logic [7:0] GADDR_GAIN_HIGH_BYTE  = 8'h04;
    localparam logic [7:0] GADDR_GAIN_LOW_NIBBLE = 8'h07;
    localparam logic [7:0] GADDR_EXTRA_GAIN      = 8'h08;
    // reset values
    localparam logic [7:0] RST_EXTRA_GAIN         = 8'h01;
    localparam logic [7:0] RST_INPUT_CHANNEL      = 8'h1f;
    localparam logic [7:0] RST_CONFIGURATION      = 8'hf8;
    localparam logic [7:0] RST_GAIN_HIGH_BYTE     = 8'hfc;
    localparam logic [3:0] RST_GAIN_LOW_NIBBLE    = 4'h0;
    // field positions
    localparam int SAR_DIV_LSB    = 3;
    localparam int SAR_DIV_W      = 5;
    localparam int REPEAT_LSB     = 1;
    localparam int GAIN_EN_BIT    = 0;
    localparam int INPUT_SEL_W    = 5;
    localparam int GAIN_NIB_LSB   = 4;
    // first input code that connects ground
    localparam logic [4:0] GROUND_FIRST_CODE = 5'h1a;
    // extra gain of 1/64 in units of 1/4096
    localparam logic [12:0] EXTRA_GAIN_UNITS = 13'h0040;
    // burst source clock from the system clock
    localparam int CLK_MHZ        = 100;
    localparam int BURST_CONVERTER_SOURCE_CLOCK_MHZ = 25;
    localparam int BURST_DIV      = (CLK_MHZ + BURST_CONVERTER_SOURCE_CLOCK_MHZ - 1) / BURST_CONVERTER_SOURCE_CLOCK_MHZ;
    localparam logic [1:0] BURST_DIV_M1 = 2'(BURST_DIV - 1);
    typedef enum logic [1:0] {AGM_IDLE, AGM_RUN, AGM_WAIT_START} agm_seq_e;
endpackage : agm_pkg

// ==== src/agm_tick_div.sv ====
// enable divider: one output pulse per (div + 1) input pulses
// assumes tick_in is a one-cycle enable on clk
`timescale 1ns/1ps
module agm_tick_div #(
    parameter int WIDTH = 5
) (
    input  wire logic             clk,
    input  wire logic             rstn,
    input  wire logic             tick_in,
    input  wire logic [WIDTH-1:0] div,
    output logic                  tick_out
);
    logic [WIDTH-1:0] cnt_ff;
    wire              wrap = tick_in && (cnt_ff >= div);

    always_ff @(posedge clk) begin
        if (!rstn) begin
            cnt_ff   <= '0;
            tick_out <= 1'b0;
        end else begin
            tick_out <= wrap;
            if (wrap)
                cnt_ff <= '0;
            else if (tick_in)
                cnt_ff <= cnt_ff + 1'b1;
        end
    end
endmodule : agm_tick_div

// ==== tb/agm_regs_tb.sv ====
// self-checking bench for the gain, channel and configuration register slice
// assumes agm_regs as top, byte register port, one 100 MHz clock
`timescale 1ns/1ps
module agm_regs_tb;
    import agm_pkg::*;
    logic        clk, rstn, sfr_wr, sfr_rd, burst_enable, convert_start, conversion_end;
    logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata, v, d;
    logic [4:0]  input_select_field, conversion_total;
    logic        ground_selected, sar_clock_tick, conversion_go, accumulate_clear;
    logic        conversion_done_set, extra_gain_bit, gain_program_enable;
    logic [11:0] gain_word;
    logic [12:0] effective_gain;
    logic [23:0] g;
    logic [31:0] rng = 32'h7d6ade5a;
    int          n_fail = 0;
    int          checks = 0;

    agm_regs dut_u (.clk(clk), .rstn(rstn), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
        .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
        .burst_enable(burst_enable), .convert_start(convert_start),
        .conversion_end(conversion_end), .input_select_field(input_select_field),
        .ground_selected(ground_selected), .sar_clock_tick(sar_clock_tick),
        .conversion_go(conversion_go), .accumulate_clear(accumulate_clear),
        .conversion_done_set(conversion_done_set), .conversion_total(conversion_total),
        .gain_word(gain_word), .extra_gain_bit(extra_gain_bit),
        .effective_gain(effective_gain), .gain_program_enable(gain_program_enable));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    function automatic int exp_total(input logic [1:0] r);
        return (r == 2'd0) ? 1 : (2 << r);
    endfunction : exp_total
    function automatic logic [12:0] exp_gain(input logic [11:0] w, input logic x);
        return {1'b0, w} + (x ? 13'h0040 : 13'h0000);
    endfunction : exp_gain

    task chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task conclude;
        $display("checks=%0d n_fail=%0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : conclude
    task wr(input logic [7:0] a, input logic [7:0] dat);
        @(posedge clk);
        sfr_addr <= a;
        sfr_wdata <= dat;
        sfr_wr <= 1'b1;
        @(posedge clk);
        sfr_wr <= 1'b0;
    endtask : wr
    task rd(input logic [7:0] a, output logic [7:0] q);
        @(posedge clk);
        sfr_addr <= a;
        sfr_rd <= 1'b1;
        @(posedge clk);
        sfr_rd <= 1'b0;
        #1 q = sfr_rdata;
    endtask : rd
    task gprog(input logic [7:0] a, input logic [7:0] dat);
        wr(ADDR_RESULT_HIGH, a);
        wr(ADDR_RESULT_LOW, dat);
    endtask : gprog
    task seq(input logic [1:0] rpt, input logic b);
        int gos, ends, dn, clr;
        logic gg, pend;
        gos = 0; ends = 0; dn = 0; clr = 0; pend = 0;
        wr(ADDR_CONVERTER_CONFIGURATION, {5'h1f, rpt, 1'b0});
        burst_enable <= b;
        convert_start <= 1'b1;
        @(posedge clk);
        convert_start <= 1'b0;
        for (int j = 0; j < 120; j++) begin
            @(negedge clk);
            gg = conversion_go;
            if (gg && gos == 0) chk(conversion_total, exp_total(rpt));
            if (conversion_done_set) chk(ends, exp_total(rpt));
            dn += conversion_done_set;
            gos += gg;
            clr += accumulate_clear;
            @(posedge clk);
            convert_start <= !b && pend && ends < exp_total(rpt);
            conversion_end <= gg;
            ends += gg;
            pend = gg;
        end
        chk(gos, exp_total(rpt));
        chk(dn, 1);
        chk(clr, 1);
    endtask : seq
    task tick(input logic b, input logic [4:0] dv, input int exp);
        int n, k;
        wr(ADDR_CONVERTER_CONFIGURATION, {dv, 3'b000});
        burst_enable <= b;
        n = 0; k = 0;
        for (int j = 0; j < 400 && k < 3; j++) begin
            @(negedge clk);
            n++;
            if (sar_clock_tick) begin
                if (k == 2) chk(n, exp);
                k++;
                n = 0;
            end
        end
        chk(k, 3);
    endtask : tick

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        #200000;
        n_fail++;
        conclude;
    end
    initial begin
        rstn = 0; sfr_wr = 0; sfr_rd = 0; sfr_addr = 0; sfr_wdata = 0;
        burst_enable = 0; convert_start = 0; conversion_end = 0;
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        #1 chk(input_select_field, 5'h1f);
        chk(ground_selected, 1'b1);
        chk(gain_word, 12'hfc0);
        chk(extra_gain_bit, 1'b1);
        chk(gain_program_enable, 1'b0);
        chk(conversion_total, 5'd1);
        @(posedge clk);
        #1 chk(effective_gain, exp_gain(12'hfc0, 1'b1));
        rd(ADDR_INPUT_CHANNEL_SELECT, v); chk(v, 8'h1f);
        rd(ADDR_CONVERTER_CONFIGURATION, v); chk(v, 8'hf8);
        $display("test reset values done");
        for (int i = 0; i < 12; i++) begin
            rng = lfsr(rng);
            d = (i < 3) ? 8'h19 + 8'(i) : rng[7:0];
            wr(ADDR_INPUT_CHANNEL_SELECT, d);
            wr(ADDR_CONVERTER_CONFIGURATION, rng[15:8]);
            rd(ADDR_INPUT_CHANNEL_SELECT, v); chk(v, {3'b000, d[4:0]});
            chk(input_select_field, d[4:0]);
            chk(ground_selected, d[4:0] >= 5'h1a);
            rd(ADDR_CONVERTER_CONFIGURATION, v); chk(v, rng[15:8]);
            chk(gain_program_enable, rng[8]);
        end
        rd(8'h55, v); chk(v, 8'h00);
        $display("test channel and configuration done");
        wr(ADDR_CONVERTER_CONFIGURATION, 8'hf8);
        gprog(GADDR_GAIN_HIGH_BYTE, 8'h00);
        @(posedge clk);
        #1 chk(gain_word, 12'hfc0);
        for (int i = 0; i < 5; i++) begin
            rng = lfsr(rng);
            g = (i == 0) ? 24'h01a06c : rng[23:0];
            wr(ADDR_CONVERTER_CONFIGURATION, 8'hf9);
            gprog(GADDR_GAIN_HIGH_BYTE, g[7:0]);
            gprog(GADDR_GAIN_LOW_NIBBLE, g[15:8]);
            gprog(GADDR_EXTRA_GAIN, g[23:16]);
            gprog(8'h05, 8'hff);
            rd(ADDR_RESULT_LOW, v); chk(v, 8'h00);
            wr(ADDR_CONVERTER_CONFIGURATION, 8'hf8);
            repeat (2) @(posedge clk);
            #1 chk(gain_word, {g[7:0], g[15:12]});
            chk(extra_gain_bit, g[16]);
            chk(effective_gain, exp_gain({g[7:0], g[15:12]}, g[16]));
        end
        $display("test gain programming done");
        for (int i = 0; i < 4; i++) seq(2'(i), 1'b1);
        seq(2'd1, 1'b0);
        seq(2'd3, 1'b0);
        $display("test repeat sequencer done");
        tick(1'b0, 5'd2, 3);
        tick(1'b0, 5'd0, 1);
        tick(1'b1, 5'd2, 12);
        $display("test sar clock done");
        conclude;
    end
endmodule : agm_regs_tb
